/* verilog/fso_test_pkg.sv */
`default_nettype none
package fso_test_pkg;

  // ==========================================================================
  // Register map, byte addresses.
  localparam logic [7:0] ADDR_CTRL     = 8'h00;
  localparam logic [7:0] ADDR_WAIT     = 8'h04;
  localparam logic [7:0] ADDR_INTERVAL = 8'h08;
  localparam logic [7:0] ADDR_STATUS   = 8'h0C;
  localparam logic [7:0] ADDR_REMAIN   = 8'h10;

  // ==========================================================================
  // Field positions.
  localparam int CTRL_ENABLE_BIT = 0;
  localparam int CTRL_MODE_LSB   = 1;
  localparam int CTRL_TRIG_LSB   = 4;
  localparam int CTRL_START_BIT  = 8;
  localparam int STAT_ACTIVE_BIT = 0;
  localparam int STAT_DUE_BIT    = 1;
  localparam int STAT_FAULT_BIT  = 2;
  localparam int STAT_FSTEP_LSB  = 4;
  localparam int STAT_STEP_LSB   = 8;
  localparam int STAT_HIGH_BIT   = 12;
  localparam int STAT_LOW_BIT    = 13;

  // ==========================================================================
  // Values after reset.
  localparam logic        ENABLE_RESET   = 1'b1;
  localparam logic [1:0]  MODE_RESET     = 2'h1;
  localparam logic [1:0]  TRIG_RESET     = 2'h0;
  localparam logic [15:0] WAIT_RESET     = 16'h000A;
  localparam logic [31:0] INTERVAL_RESET = 32'h0000_0E10;

  // ==========================================================================
  // Timing.
  localparam int SYS_CLK_MHZ      = 50;
  localparam int MON_CYCLE_US     = 1000;
  localparam int MON_CYCLE_CYCLES = MON_CYCLE_US * SYS_CLK_MHZ;

  // ==========================================================================
  // Test pattern, bit n belongs to step n.
  localparam int          STEP_COUNT = 5;
  localparam logic [2:0]  LAST_STEP  = 3'h4;
  localparam logic [4:0]  PAT_HIGH   = 5'h0A;
  localparam logic [4:0]  PAT_LOW    = 5'h06;
  localparam logic [4:0]  EXP_MODE1  = 5'h08;
  localparam logic [4:0]  EXP_MODE2  = 5'h11;
  localparam logic [4:0]  EXP_MODE3  = 5'h1D;
  localparam logic [1:0]  MODE_ONE   = 2'h1;
  localparam logic [1:0]  MODE_TWO   = 2'h2;
  localparam logic [1:0]  MODE_THREE = 2'h3;

  // ==========================================================================
  // Types.
  typedef enum logic [1:0] {
    SEQ_IDLE,
    SEQ_WAIT
  } seq_e;

  typedef struct packed {
    logic       test_active_alarm;
    logic       test_due_alarm;
    logic       test_fault;
    logic [2:0] fault_step;
  } alarm_s;

endpackage
`default_nettype wire

/* verilog/failsafe_output_test_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none

// Notes on behaviour
// [RQ1] A rising edge on the selected trigger source starts one output test.
// [RQ2] Error-free completion reloads the interval timer; expiry raises the due alarm.
// [RQ3] The due alarm is set by every reset, whatever the timer holds.
// [RQ4] Three modes choose the expected feedback pattern and the feedback source.
// [RQ5] The enable bit decides whether output zero is tested with feedback evaluation.
// [RQ6] Each step allows up to the wait time for feedback to be recognized.
// [RQ7] The active alarm stands while the sequence runs.
// [RQ8] The active alarm clears when the sequence completes or faults; the due alarm clears only when it completes.
// [RQ9] A step error raises the fault; its value names the failing step, 1 to 5.
// [RQ10] Whole test stays within eight monitoring cycles plus six wait times.
// [RQ11] Mode one: switches off-off, on-on, off-on, on-off, off-off; feedback 0,0,0,1,0.
// [RQ12] Mode two: same switch steps; read-back expected 1,0,0,0,1.
// [RQ13] Mode three: same switch steps; read-back expected 1,0,1,1,1.
// [RQ14] The outside circuit uses the feedback input for test feedback only.
// [RQ15] Sensors on the failsafe inputs are not exercised by this sequencer.
// [RQ16] Each step drives switches, waits, compares; a mismatch is a step error.
// [RQ17] A faulted test neither reloads the timer nor clears the due alarm.
module failsafe_output_test_sequencer #(
  parameter int MON_CYCLE_CYCLES = fso_test_pkg::MON_CYCLE_CYCLES,
  parameter int TRIG_WIDTH       = 4
) (
  input  wire logic                  sys_clk_in,
  input  wire logic                  rst_n_in,
  input  wire logic                  hsel_in,
  input  wire logic [31:0]           haddr_in,
  input  wire logic [1:0]            htrans_in,
  input  wire logic                  hwrite_in,
  input  wire logic [2:0]            hsize_in,
  input  wire logic [31:0]           hwdata_in,
  input  wire logic                  hready_in,
  output logic      [31:0]           hrdata_out,
  output logic                       hreadyout_out,
  output logic                       hresp_out,
  input  wire logic [TRIG_WIDTH-1:0] trigger_in,
  input  wire logic                  feedback_a_in,
  input  wire logic                  feedback_b_in,
  output logic                       switch_high_out,
  output logic                       switch_low_out,
  output fso_test_pkg::alarm_s       alarms_out
);

  // ==========================================================================
  // State.
  typedef struct packed {
    // Sequencer and timers.
    fso_test_pkg::seq_e    state;
    logic [2:0]            step;
    logic [15:0]           wait_cnt;
    logic [31:0]           interval_cnt;
    logic [31:0]           div_cnt;
    logic                  tick;

    // Pin synchronisers and trigger edge detection.
    logic [TRIG_WIDTH-1:0] trig_meta;
    logic [TRIG_WIDTH-1:0] trig_sync;
    logic                  trig_prev;
    logic                  start_pend;
    logic [1:0]            fb_meta;
    logic [1:0]            fb_sync;

    // Software configuration.
    logic                  enable;
    logic [1:0]            mode;
    logic [1:0]            trig_sel;
    logic [15:0]           wait_time;
    logic [31:0]           interval;

    // Alarms and switch drive.
    logic                  active;
    logic                  due;
    logic                  fault;
    logic [2:0]            fault_step;
    logic                  sw_high;
    logic                  sw_low;

    // Bus data phase.
    logic                  dp_valid;
    logic                  dp_write;
    logic [7:0]            dp_addr;
    logic [31:0]           hrdata;
  } state_s;

  state_s st_q;
  state_s st_d;

  // ==========================================================================
  // Next state.
  always_comb begin
    logic       trig_now;
    logic       fb_now;
    logic [4:0] expect_pat;
    logic       advance;
    logic       step_error;
    logic       fault_set;
    logic       sw_start;
    logic       ap_take;
    logic       sel_write;

    trig_now   = 1'b0;
    fb_now     = 1'b0;
    expect_pat = fso_test_pkg::EXP_MODE1;
    advance    = 1'b0;
    step_error = 1'b0;
    fault_set  = 1'b0;
    sw_start   = 1'b0;
    sel_write  = 1'b0;
    ap_take    = hsel_in && htrans_in[1] && hready_in;
    st_d       = st_q;

    // ========================================================================
    // Pins cross into the clock domain through two flip-flops.
    // Only the two feedback pins are read back; failsafe input sensors are never driven.
    st_d.trig_meta = trigger_in;
    st_d.trig_sync = st_q.trig_meta;
    st_d.fb_meta   = {feedback_b_in, feedback_a_in}; // RQ15
    st_d.fb_sync   = st_q.fb_meta;

    // ========================================================================
    // Monitoring cycle tick, one clock long once every MON_CYCLE_CYCLES clocks.
    // Everything below that steps the test advances on this tick only.
    if (st_q.div_cnt >= 32'(MON_CYCLE_CYCLES - 1)) begin
      st_d.div_cnt = 32'h0000_0000;
      st_d.tick    = 1'b1;
    end else begin
      st_d.div_cnt = st_q.div_cnt + 32'h0000_0001;
      st_d.tick    = 1'b0;
    end

    // ========================================================================
    // Register writes in the data phase.
    // The start bit is a one-clock strobe and is never stored.
    if (st_q.dp_valid && st_q.dp_write) begin
      case (st_q.dp_addr)
        fso_test_pkg::ADDR_CTRL: begin
          st_d.enable   = hwdata_in[fso_test_pkg::CTRL_ENABLE_BIT];
          st_d.mode     = hwdata_in[fso_test_pkg::CTRL_MODE_LSB +: 2];
          st_d.trig_sel = hwdata_in[fso_test_pkg::CTRL_TRIG_LSB +: 2];
          sw_start      = hwdata_in[fso_test_pkg::CTRL_START_BIT];
          sel_write     = 1'b1;
        end
        fso_test_pkg::ADDR_WAIT: begin
          st_d.wait_time = hwdata_in[15:0];
        end
        fso_test_pkg::ADDR_INTERVAL: begin
          st_d.interval = hwdata_in;
        end
        fso_test_pkg::ADDR_STATUS: begin
          if (hwdata_in[fso_test_pkg::STAT_FAULT_BIT]) begin
            st_d.fault      = 1'b0;
            st_d.fault_step = 3'h0;
          end
        end
        default: begin
          // Writes to read-only and unmapped words are dropped.
        end
      endcase
    end

    // ========================================================================
    // Trigger source selection and edge detection.
    // Triggers that arrive while a test runs are dropped, not queued.
    trig_now       = st_q.trig_sync[st_q.trig_sel];
    st_d.trig_prev = trig_now;
    // A new source selection must not look like an edge in its first cycle.
    if (sel_write) begin
      st_d.trig_prev = st_q.trig_sync[st_d.trig_sel];
    end
    if (st_q.state == fso_test_pkg::SEQ_IDLE && ((trig_now && !st_q.trig_prev) || sw_start)) begin
      st_d.start_pend = 1'b1; // RQ1
    end

    // ========================================================================
    // Feedback source and expected pattern per mode.
    // The first matching sample ends a step; a slow answer only uses up wait time.
    case (st_q.mode) // RQ4
      fso_test_pkg::MODE_TWO: begin
        fb_now     = st_q.fb_sync[1];
        expect_pat = fso_test_pkg::EXP_MODE2; // RQ12
      end
      fso_test_pkg::MODE_THREE: begin
        fb_now     = st_q.fb_sync[1];
        expect_pat = fso_test_pkg::EXP_MODE3; // RQ13
      end
      default: begin
        fb_now     = st_q.fb_sync[0];
        expect_pat = fso_test_pkg::EXP_MODE1; // RQ11
      end
    endcase

    // ========================================================================
    // Interval timer, counted in monitoring cycles.
    // It keeps counting during a test and holds its value while the due alarm stands.
    if (st_q.tick && !st_q.due) begin
      if (st_q.interval_cnt == 32'h0000_0000) begin
        st_d.due = 1'b1; // RQ2
      end else begin
        st_d.interval_cnt = st_q.interval_cnt - 32'h0000_0001;
      end
    end

    // ========================================================================
    // Sequencer, stepping once per monitoring cycle.
    if (st_q.tick) begin
      case (st_q.state)
        fso_test_pkg::SEQ_IDLE: begin
          if (st_q.start_pend) begin
            // Step one drives off-off, so the output starts from its safe state.
            st_d.start_pend = 1'b0;
            st_d.active     = 1'b1; // RQ7
            st_d.step       = 3'h0;
            st_d.wait_cnt   = 16'h0000;
            st_d.sw_high    = st_q.enable && fso_test_pkg::PAT_HIGH[0]; // RQ5
            st_d.sw_low     = st_q.enable && fso_test_pkg::PAT_LOW[0];
            st_d.state      = fso_test_pkg::SEQ_WAIT;
          end
        end
        fso_test_pkg::SEQ_WAIT: begin
          // An output left out of the test only runs out its wait on every step.
          if (!st_q.enable) begin
            advance = st_q.wait_cnt >= st_q.wait_time; // RQ5
          end else if (fb_now == expect_pat[st_q.step]) begin
            advance = 1'b1; // RQ16
          end else if (st_q.wait_cnt >= st_q.wait_time) begin
            step_error = 1'b1; // RQ6 RQ16
          end
          if (!advance && !step_error) begin
            st_d.wait_cnt = st_q.wait_cnt + 16'h0001;
          end

          // A fault leaves the interval timer and the due alarm as they stand.
          if (step_error) begin
            fault_set       = 1'b1; // RQ9
            st_d.fault_step = st_q.step + 3'h1; // RQ9
            st_d.active     = 1'b0;
            st_d.sw_high    = 1'b0;
            st_d.sw_low     = 1'b0;
            st_d.state      = fso_test_pkg::SEQ_IDLE; // RQ17
          end else if (advance && st_q.step == fso_test_pkg::LAST_STEP) begin
            // Only a clean pass reloads the timer and drops both alarms.
            st_d.active       = 1'b0; // RQ8
            st_d.due          = 1'b0; // RQ8
            st_d.interval_cnt = st_q.interval; // RQ2
            st_d.sw_high      = 1'b0;
            st_d.sw_low       = 1'b0;
            st_d.state        = fso_test_pkg::SEQ_IDLE;
          end else if (advance) begin
            // The next step's pattern is applied; an untested output stays off.
            st_d.step     = st_q.step + 3'h1;
            st_d.wait_cnt = 16'h0000; // RQ10
            st_d.sw_high  = st_q.enable && fso_test_pkg::PAT_HIGH[st_q.step + 3'h1]; // RQ11
            st_d.sw_low   = st_q.enable && fso_test_pkg::PAT_LOW[st_q.step + 3'h1];
          end
        end
        default: begin
          st_d.state = fso_test_pkg::SEQ_IDLE;
        end
      endcase
    end

    // ========================================================================
    // A fault raised in the cycle of a software clear still stands.
    if (fault_set) begin
      st_d.fault = 1'b1;
    end

    // ========================================================================
    // Address phase capture and read data preparation.
    // Read data stands for the single data phase that follows and is zero otherwise.
    st_d.dp_valid = ap_take;
    st_d.dp_write = ap_take && hwrite_in;
    st_d.dp_addr  = haddr_in[7:0];
    st_d.hrdata   = 32'h0000_0000;
    if (ap_take && !hwrite_in) begin
      case (haddr_in[7:0])
        fso_test_pkg::ADDR_CTRL: begin
          // The start strobe always reads back as zero.
          st_d.hrdata[fso_test_pkg::CTRL_ENABLE_BIT]   = st_q.enable;
          st_d.hrdata[fso_test_pkg::CTRL_MODE_LSB +: 2] = st_q.mode;
          st_d.hrdata[fso_test_pkg::CTRL_TRIG_LSB +: 2] = st_q.trig_sel;
        end
        fso_test_pkg::ADDR_WAIT: begin
          st_d.hrdata[15:0] = st_q.wait_time;
        end
        fso_test_pkg::ADDR_INTERVAL: begin
          st_d.hrdata = st_q.interval;
        end
        fso_test_pkg::ADDR_STATUS: begin
          // The step index counts from zero; the fault value counts from one.
          st_d.hrdata[fso_test_pkg::STAT_ACTIVE_BIT]     = st_q.active;
          st_d.hrdata[fso_test_pkg::STAT_DUE_BIT]        = st_q.due;
          st_d.hrdata[fso_test_pkg::STAT_FAULT_BIT]      = st_q.fault;
          st_d.hrdata[fso_test_pkg::STAT_FSTEP_LSB +: 3] = st_q.fault_step;
          st_d.hrdata[fso_test_pkg::STAT_STEP_LSB +: 3]  = st_q.step;
          st_d.hrdata[fso_test_pkg::STAT_HIGH_BIT]       = st_q.sw_high;
          st_d.hrdata[fso_test_pkg::STAT_LOW_BIT]        = st_q.sw_low;
        end
        fso_test_pkg::ADDR_REMAIN: begin
          st_d.hrdata = st_q.interval_cnt;
        end
        default: begin
          st_d.hrdata = 32'h0000_0000;
        end
      endcase
    end
  end

  // ==========================================================================
  // Registers.
  always_ff @(posedge sys_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_q              <= '0;
      st_q.state        <= fso_test_pkg::SEQ_IDLE;
      st_q.enable       <= fso_test_pkg::ENABLE_RESET;
      st_q.mode         <= fso_test_pkg::MODE_RESET;
      st_q.trig_sel     <= fso_test_pkg::TRIG_RESET;
      st_q.wait_time    <= fso_test_pkg::WAIT_RESET;
      st_q.interval     <= fso_test_pkg::INTERVAL_RESET;
      st_q.interval_cnt <= fso_test_pkg::INTERVAL_RESET;
      // Reset raises the due alarm, so every power-up asks for a test.
      st_q.due          <= 1'b1; // RQ3
    end else begin
      st_q <= st_d;
    end
  end

  // ==========================================================================
  // Outputs.
  // The bus never inserts wait states and always answers OKAY.
  assign hrdata_out                   = st_q.hrdata;
  assign hreadyout_out                = 1'b1;
  assign hresp_out                    = 1'b0;
  assign switch_high_out              = st_q.sw_high;
  assign switch_low_out               = st_q.sw_low;
  assign alarms_out.test_active_alarm = st_q.active;
  assign alarms_out.test_due_alarm    = st_q.due;
  assign alarms_out.test_fault        = st_q.fault;
  assign alarms_out.fault_step        = st_q.fault_step;

endmodule
`default_nettype wire

/* testbench/fso_checker_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module fso_checker (
  input wire logic                 sys_clk_in,
  input wire logic                 rst_n_in,
  input wire logic                 hsel_in,
  input wire logic [31:0]          haddr_in,
  input wire logic [1:0]           htrans_in,
  input wire logic                 hwrite_in,
  input wire logic [31:0]          hrdata_out,
  input wire logic                 switch_high_out,
  input wire logic                 switch_low_out,
  input wire fso_test_pkg::alarm_s alarms_out
);
  default clocking cb @(posedge sys_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  wire logic       act = alarms_out.test_active_alarm;
  wire logic       due = alarms_out.test_due_alarm;
  wire logic       flt = alarms_out.test_fault;
  wire logic [1:0] sw  = {switch_high_out, switch_low_out};
  property p_reset_due;
    $rose(rst_n_in) |-> due;
  endproperty
  a_reset_due: assert property (p_reset_due) else $error("due low after reset");
  property p_idle_sw;
    !act |-> sw == 2'b00;
  endproperty
  a_idle_sw: assert property (p_idle_sw) else $error("switch on while idle");
  property p_sw_order;
    act && $past(act) && sw != $past(sw) |-> {$past(sw), sw} inside {4'h3, 4'hD, 4'h6, 4'h8};
  endproperty
  a_sw_order: assert property (p_sw_order) else $error("switch order wrong");
  property p_start_due;
    $rose(act) |-> !$fell(due);
  endproperty
  a_start_due: assert property (p_start_due) else $error("due changed at start");
  property p_due_fall;
    $fell(due) |-> $fell(act) && !flt;
  endproperty
  a_due_fall: assert property (p_due_fall) else $error("due cleared early");
  property p_ok_end;
    $fell(act) && !flt |-> !due;
  endproperty
  a_ok_end: assert property (p_ok_end) else $error("due kept after pass");
  property p_fault;
    $rose(flt) |-> $fell(act) && alarms_out.fault_step inside {[3'd1:3'd5]};
  endproperty
  a_fault: assert property (p_fault) else $error("bad fault report");
  property p_unmapped;
    hsel_in && htrans_in[1] && !hwrite_in && haddr_in[7:0] == 8'h14 |=> hrdata_out == 32'h0;
  endproperty
  a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
endmodule
bind failsafe_output_test_sequencer fso_checker chk_i (
  .sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .hsel_in(hsel_in),
  .haddr_in(haddr_in), .htrans_in(htrans_in), .hwrite_in(hwrite_in),
  .hrdata_out(hrdata_out), .switch_high_out(switch_high_out),
  .switch_low_out(switch_low_out), .alarms_out(alarms_out));
`default_nettype wire

/* testbench/fso_load_model.sv */
`timescale 1ns/100ps
`default_nettype none
module fso_load_model (
  input  wire logic       sys_clk_in,
  input  wire logic       switch_high_in,
  input  wire logic       switch_low_in,
  input  wire logic [1:0] mode_in,
  input  wire logic [3:0] delay_in,
  input  wire logic [2:0] bad_step_in,
  output logic            feedback_a_out,
  output logic            feedback_b_out
);
  logic [15:0] a_q = '0;
  logic [15:0] b_q = '0;
  logic        tog_q = 1'b0;
  logic [1:0]  sw;
  logic [1:0]  bad_sw;
  logic        bad;
  // A nonzero bad step flips the response for the switch state of that step.
  assign sw = {switch_high_in, switch_low_in};
  assign bad_sw = 2'(8'h9C >> (2 * (bad_step_in - 3'h1)));
  assign bad = bad_step_in != 3'h0 && sw == bad_sw;
  always_ff @(posedge sys_clk_in) begin
    a_q <= {a_q[14:0], (sw == 2'b10) ^ bad};
    b_q <= {b_q[14:0], (mode_in == 2'h2 ? sw == 2'b00 : sw != 2'b11) ^ bad};
    tog_q <= !tog_q;
  end
  // Mode one leaves the read-back line unused, so it holds no stable level.
  assign feedback_a_out = a_q[delay_in];
  assign feedback_b_out = mode_in < 2'h2 ? tog_q : b_q[delay_in];
endmodule
`default_nettype wire

/* testbench/tb_failsafe_output_test_sequencer.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_failsafe_output_test_sequencer;
  localparam int MON = 4;
  localparam int WT = 3;
  localparam logic [31:0] RST [6] = '{32'h3, 32'hA, 32'hE10, 32'h2, 32'hE10, 32'h0};
  logic sys_clk = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic hready;
  logic fa;
  logic fb;
  logic sh;
  logic sl;
  logic [1:0] htrans = 2'h0;
  logic [1:0] mode = 2'h1;
  logic [1:0] sw_or;
  logic [2:0] bad = 3'h0;
  logic [3:0] trig = 4'h0;
  logic [3:0] dly = 4'h0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [31:0] hrdata;
  logic [31:0] rd;
  logic [31:0] seed = 32'hbc38_cb83;
  fso_test_pkg::alarm_s al;
  int fails = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;
  failsafe_output_test_sequencer #(.MON_CYCLE_CYCLES(MON)) dut (
    .sys_clk_in(sys_clk), .rst_n_in(rst_n), .hsel_in(hsel), .haddr_in(haddr),
    .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2), .hwdata_in(hwdata),
    .hready_in(hready), .hrdata_out(hrdata), .hreadyout_out(hready), .hresp_out(),
    .trigger_in(trig), .feedback_a_in(fa), .feedback_b_in(fb),
    .switch_high_out(sh), .switch_low_out(sl), .alarms_out(al));
  fso_load_model load (
    .sys_clk_in(sys_clk), .switch_high_in(sh), .switch_low_in(sl), .mode_in(mode),
    .delay_in(dly), .bad_step_in(bad), .feedback_a_out(fa), .feedback_b_out(fb));
  initial forever #10 sys_clk = ~sys_clk;
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [31:0] ctrl(logic en, logic [1:0] m, logic [1:0] s, logic go);
    return {23'h0, go, 2'h0, s, 1'b0, m, en};
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    @(posedge sys_clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= {24'h0, a};
    hwrite <= wr;
    do @(posedge sys_clk); while (hready !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    do @(posedge sys_clk); while (hready !== 1'b1);
    rd = hrdata;
  endtask
  task automatic wait_act(input logic v, input int lim);
    n = 0;
    while (al.test_active_alarm !== v && n < lim) begin
      @(posedge sys_clk);
      sw_or = sw_or | {sh, sl};
      n++;
    end
    chk(al.test_active_alarm, v);
  endtask
  task automatic run(input logic en, input logic [1:0] m, input logic [2:0] b, input logic go);
    logic [1:0] s;
    s = 2'(rnd());
    mode <= m;
    bad <= b;
    // A faulty step gets a prompt answer, so a stale sample cannot pass it.
    dly <= (b != 3'h0) ? 4'h0 : 4'(rnd() % 9);
    ahb(1'b1, fso_test_pkg::ADDR_CTRL, ctrl(en, m, s, go));
    trig[s] <= !go;
    wait_act(1'b1, 3 * MON + 8);
    trig <= 4'h0;
    sw_or = 2'h0;
    @(posedge sys_clk);
    trig[s] <= !go;
    wait_act(1'b0, 30 * MON);
    chk(n <= MON * (8 + 6 * WT), 1'b1);
    trig <= 4'h0;
    repeat (3 * MON) @(posedge sys_clk);
    chk(al.test_active_alarm, 1'b0);
  endtask
  task automatic results();
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 10000) begin
      fails++;
      results();
    end
  end
  initial begin
    repeat (8) @(posedge sys_clk);
    rst_n <= 1'b1;
    @(posedge sys_clk);
    chk(32'(al), 32'h10);
    ahb(1'b1, fso_test_pkg::ADDR_REMAIN, 32'hFFFF);
    for (int i = 0; i < 6; i++) begin
      ahb(1'b0, 8'(4 * i), '0);
      chk(rd, RST[i]);
    end
    ahb(1'b1, fso_test_pkg::ADDR_WAIT, WT);
    ahb(1'b1, fso_test_pkg::ADDR_INTERVAL, 32'd20);
    for (int m = 1; m <= 3; m++) begin
      run(1'b1, 2'(m), 3'h0, 1'b0);
      chk(32'(al), 32'h0);
    end
    repeat (12 * MON) @(posedge sys_clk);
    chk(al.test_due_alarm, 1'b0);
    n = 0;
    while (al.test_due_alarm !== 1'b1 && n < 12 * MON) begin
      @(posedge sys_clk);
      n++;
    end
    chk(al.test_due_alarm, 1'b1);
    for (int k = 1; k <= 4; k++) begin
      run(1'b1, 2'(1 + rnd() % 3), 3'(k), 1'b0);
      chk(32'(al), 32'h18 | k);
      ahb(1'b0, fso_test_pkg::ADDR_REMAIN, '0);
      chk(rd, 32'h0);
      ahb(1'b1, fso_test_pkg::ADDR_STATUS, 32'h4);
      @(posedge sys_clk);
      chk(32'(al), 32'h10);
    end
    run(1'b0, 2'h1, 3'h1, 1'b1);
    chk(32'(al), 32'h0);
    chk(sw_or, 2'h0);
    results();
  end
endmodule
`default_nettype wire
